// ===== rtl/apm_top.sv
`timescale 1ns/1ps
`include "apm_defines.svh"


module apm_top
  import apm_pkg::*;
#(
  parameter int BASE_CYCLES   = `APM_BASE_CYCLES,
  parameter int SECOND_CYCLES = `APM_SECOND_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire apm_regbus_t reg_bus,
  input  wire apm_sample_t sample_in,
  output logic [7:0]       reg_rdata,
  output apm_mode_t        mode,
  output logic             sensing_en,
  output logic             low_power_active,
  output logic             sample_tick,
  output logic             convert_tick
);

  localparam int PW = `APM_PERIOD_W;
  localparam int SW = `APM_SEC_CNT_W;

  apm_cfg_t            cfg;
  apm_mode_t           next_mode;
  logic                measure_en;
  logic                autosleep_en;
  logic                low_power_sel;
  logic [3:0]          rate_code;
  logic                activity;
  logic [SW-1:0]       sec_cnt;
  logic [7:0]          idle_secs;
  logic                idle_expired;
  logic [PW-1:0]       odr_period;
  logic                odr_tick;
  logic                skip_phase;

  initial begin
    if (BASE_CYCLES < 1 || BASE_CYCLES * 512 >= (1 << PW)) begin
      $error("apm_top: BASE_CYCLES out of range");
    end
    if (SECOND_CYCLES < 1 || SECOND_CYCLES >= (1 << SW)) begin
      $error("apm_top: SECOND_CYCLES out of range");
    end
  end

  // ****************************************************************
  // Rate decode
  // ****************************************************************
  // Codes below the slowest listed rate are clamped to it
  function automatic logic [PW-1:0] rate_period(input logic [3:0] code);
    logic [3:0] c;
    c = (code < `APM_RATE_CODE_MIN) ? `APM_RATE_CODE_MIN : code;
    rate_period = PW'(BASE_CYCLES) << (`APM_RATE_CODE_MAX - c);
  endfunction : rate_period

  // Folded at elaboration so the reset branch loads a plain constant
  localparam logic [PW-1:0] RST_PERIOD =
    rate_period(4'(`APM_RST_RATE_SELECT));

  // ****************************************************************
  // Registers
  // ****************************************************************
  apm_regfile u_regs (
    .clock (clock),
    .nrst  (nrst),
    .bus   (reg_bus),
    .cfg   (cfg),
    .rdata (reg_rdata)
  );

  assign measure_en    = cfg.power_control[`APM_PC_MEASURE_BIT];
  assign autosleep_en  = cfg.power_control[`APM_PC_AUTO_SLEEP_BIT] &&
                         cfg.power_control[`APM_PC_LINK_BIT];
  assign low_power_sel = cfg.rate_select[`APM_RS_LOW_POWER_BIT];
  assign rate_code     = cfg.rate_select[`APM_RS_CODE_MSB:0];

  // ****************************************************************
  // Activity detection
  // ****************************************************************
  // Only a strict excess counts; equal to threshold stays idle
  assign activity = sample_in.valid &&
                    (sample_in.x > cfg.inact_thresh ||
                     sample_in.y > cfg.inact_thresh ||
                     sample_in.z > cfg.inact_thresh);

  // Second prescaler, runs only while measuring and quiet
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_cnt <= '0;
    end else if (mode != APM_MEASURE || activity) begin
      sec_cnt <= '0;
    end else if (sec_cnt >= SW'(SECOND_CYCLES - 1)) begin
      sec_cnt <= '0;
    end else begin
      sec_cnt <= sec_cnt + SW'(1);
    end
  end

  // Whole idle seconds, saturating so a long quiet spell never wraps
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_secs <= 8'h00;
    end else if (mode != APM_MEASURE || activity) begin
      idle_secs <= 8'h00;
    end else if (sec_cnt >= SW'(SECOND_CYCLES - 1) &&
                 idle_secs != 8'hff) begin
      idle_secs <= idle_secs + 8'h01;
    end
  end

  assign idle_expired = idle_secs >= cfg.inact_time;

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  always_comb begin
    next_mode = mode;
    unique case (mode)
      APM_STANDBY: begin
        if (measure_en) begin
          next_mode = APM_MEASURE;
        end
      end
      APM_MEASURE: begin
        if (!measure_en) begin
          next_mode = APM_STANDBY;
        end else if (autosleep_en && idle_expired && !activity) begin
          next_mode = APM_SLEEP;
        end
      end
      APM_SLEEP: begin
        if (!measure_en) begin
          next_mode = APM_STANDBY;
        end else if (activity || !autosleep_en) begin
          next_mode = APM_MEASURE;
        end
      end
      default: next_mode = APM_STANDBY;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode <= APM_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // Sensing chain power follows the mode; registered from next_mode, so it
  // changes on the same edge as mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sensing_en <= 1'b0;
    end else begin
      sensing_en <= (next_mode != APM_STANDBY);
    end
  end

  // ****************************************************************
  // Output data rate
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      odr_period <= RST_PERIOD;
    end else if (next_mode == APM_SLEEP) begin
      odr_period <= rate_period(`APM_SLEEP_RATE_CODE);
    end else begin
      odr_period <= rate_period(rate_code);
    end
  end

  apm_rate_div #(
    .PERIOD_W (PW)
  ) u_odr_div (
    .clock  (clock),
    .nrst   (nrst),
    .run    (next_mode != APM_STANDBY),
    .period (odr_period),
    .tick   (odr_tick)
  );

  // Low power converts on every other output tick; the output rate holds
  // and the skipped slot repeats the last result at slightly more noise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      skip_phase <= 1'b0;
    end else if (mode == APM_STANDBY || !low_power_sel) begin
      skip_phase <= 1'b0;
    end else if (odr_tick) begin
      skip_phase <= !skip_phase;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sample_tick      <= 1'b0;
      convert_tick     <= 1'b0;
      low_power_active <= 1'b0;
    end else begin
      sample_tick      <= odr_tick && mode != APM_STANDBY;
      convert_tick     <= odr_tick && mode != APM_STANDBY &&
                          (!low_power_sel || !skip_phase);
      low_power_active <= low_power_sel && mode != APM_STANDBY;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RESET_STANDBY: assert property (@(posedge clock) disable iff (!nrst)
    !$past(nrst) |-> mode == APM_STANDBY && !sensing_en)
    else $error("not in standby after reset");

  AST_MEASURE_ENTRY: assert property (@(posedge clock) disable iff (!nrst)
    mode == APM_STANDBY && measure_en |=> mode == APM_MEASURE)
    else $error("measure bit did not start measuring");

  AST_STANDBY_RETURN: assert property (@(posedge clock) disable iff (!nrst)
    mode != APM_STANDBY && !measure_en |=>
      mode == APM_STANDBY ##1 !sensing_en)
    else $error("cleared measure bit did not reach standby");

  AST_NO_SAMPLE_STANDBY: assert property (@(posedge clock)
    disable iff (!nrst)
    mode == APM_STANDBY && $past(mode) == APM_STANDBY |->
      !sample_tick && !convert_tick)
    else $error("sample taken in standby");

  AST_CONVERT_IN_SLOT: assert property (@(posedge clock) disable iff (!nrst)
    convert_tick |-> sample_tick)
    else $error("conversion outside an output slot");

  AST_FULL_POWER_ALL: assert property (@(posedge clock) disable iff (!nrst)
    sample_tick && !$past(low_power_sel) |-> convert_tick)
    else $error("normal power skipped a conversion");

  AST_RATE_PERIOD: assert property (@(posedge clock) disable iff (!nrst)
    mode == APM_MEASURE && $stable(rate_code) && $past(mode) == APM_MEASURE
      |-> odr_period == rate_period(rate_code))
    else $error("output rate period mismatch");

  AST_SLEEP_RATE: assert property (@(posedge clock) disable iff (!nrst)
    mode == APM_SLEEP |->
      odr_period == rate_period(`APM_SLEEP_RATE_CODE))
    else $error("sleep rate not applied");

  AST_SLEEP_GATE: assert property (@(posedge clock) disable iff (!nrst)
    mode == APM_SLEEP && $past(mode) == APM_MEASURE |->
      $past(autosleep_en))
    else $error("sleep without both enable bits");

  AST_SLEEP_ENTRY: assert property (@(posedge clock) disable iff (!nrst)
    mode == APM_MEASURE && measure_en && autosleep_en &&
      idle_secs >= cfg.inact_time && !activity |=> mode == APM_SLEEP)
    else $error("idle time elapsed without sleeping");

  AST_IDLE_RESTART: assert property (@(posedge clock) disable iff (!nrst)
    activity |=> idle_secs == 8'h00 && sec_cnt == '0)
    else $error("idle count survived activity");

  AST_COUNT_ONLY_MEASURE: assert property (@(posedge clock)
    disable iff (!nrst)
    mode != APM_MEASURE |=> sec_cnt == '0)
    else $error("idle counted outside measurement");

  COV_MEASURE: cover property (@(posedge clock) disable iff (!nrst)
    mode == APM_STANDBY ##1 mode == APM_MEASURE);

  COV_AUTOSLEEP: cover property (@(posedge clock) disable iff (!nrst)
    mode == APM_MEASURE ##1 mode == APM_SLEEP);

  COV_WAKE: cover property (@(posedge clock) disable iff (!nrst)
    mode == APM_SLEEP ##1 mode == APM_MEASURE);

  COV_LOW_POWER: cover property (@(posedge clock) disable iff (!nrst)
    sample_tick && !convert_tick);

endmodule : apm_top

// ===== rtl/apm_defines.svh
`ifndef APM_DEFINES_SVH
`define APM_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define APM_ADDR_W              6
`define APM_ADDR_INACT_THRESH   6'h25
`define APM_ADDR_INACT_TIME     6'h26
`define APM_ADDR_RATE_SELECT    6'h2c
`define APM_ADDR_POWER_CONTROL  6'h2d

// ****************************************************************
// Field positions
// ****************************************************************
`define APM_PC_MEASURE_BIT      3
`define APM_PC_AUTO_SLEEP_BIT   4
`define APM_PC_LINK_BIT         5
`define APM_RS_LOW_POWER_BIT    4
`define APM_RS_CODE_MSB         3

// ****************************************************************
// Reset values
// ****************************************************************
`define APM_RST_INACT_THRESH    8'h00
`define APM_RST_INACT_TIME      8'h00
`define APM_RST_RATE_SELECT     8'h0a
`define APM_RST_POWER_CONTROL   8'h00
`define APM_RST_RDATA           8'h00

// ****************************************************************
// Rate codes and timing
// ****************************************************************
`define APM_RATE_CODE_MAX       4'hf
`define APM_RATE_CODE_MIN       4'h6
`define APM_SLEEP_RATE_CODE     4'h6
`define APM_CLK_HZ              10000000
`define APM_ODR_MAX_HZ          3200
`define APM_INACT_UNIT_S        1
`define APM_BASE_CYCLES         (`APM_CLK_HZ / `APM_ODR_MAX_HZ)
`define APM_SECOND_CYCLES       (`APM_CLK_HZ * `APM_INACT_UNIT_S)
`define APM_PERIOD_W            21
`define APM_SEC_CNT_W           24

`endif

// ===== rtl/apm_pkg.sv
package apm_pkg;

  typedef enum logic [1:0] {
    APM_STANDBY = 2'b00,
    APM_MEASURE = 2'b01,
    APM_SLEEP   = 2'b10
  } apm_mode_t;

  // One register access from the serial port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } apm_regbus_t;

  typedef struct packed {
    logic [7:0] inact_thresh;
    logic [7:0] inact_time;
    logic [7:0] rate_select;
    logic [7:0] power_control;
  } apm_cfg_t;

  // Per-axis acceleration magnitude from the sensing chain
  typedef struct packed {
    logic       valid;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } apm_sample_t;

endpackage : apm_pkg

// ===== rtl/apm_rate_div.sv
`timescale 1ns/1ps
`include "apm_defines.svh"

module apm_rate_div
  import apm_pkg::*;
#(
  parameter int PERIOD_W = `APM_PERIOD_W
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                run,
  input  wire logic [PERIOD_W-1:0] period,
  output logic                     tick
);

  logic [PERIOD_W-1:0] count;

  initial begin
    if (PERIOD_W < 2) begin
      $error("apm_rate_div: PERIOD_W too small");
    end
  end

  // Restart from a full period whenever stopped, so the first tick after
  // wake-up is a whole period away
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count + PERIOD_W'(1) >= period) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + PERIOD_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : apm_rate_div

// ===== rtl/apm_regfile.sv
`timescale 1ns/1ps
`include "apm_defines.svh"

module apm_regfile
  import apm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire apm_regbus_t bus,
  output apm_cfg_t         cfg,
  output logic [7:0]       rdata
);

  // ****************************************************************
  // Storage, open in every mode and never touched by mode changes
  // ****************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg.inact_thresh  <= `APM_RST_INACT_THRESH;
      cfg.inact_time    <= `APM_RST_INACT_TIME;
      cfg.rate_select   <= `APM_RST_RATE_SELECT;
      cfg.power_control <= `APM_RST_POWER_CONTROL;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `APM_ADDR_INACT_THRESH:  cfg.inact_thresh  <= bus.wdata;
        `APM_ADDR_INACT_TIME:    cfg.inact_time    <= bus.wdata;
        `APM_ADDR_RATE_SELECT:   cfg.rate_select   <= bus.wdata;
        `APM_ADDR_POWER_CONTROL: cfg.power_control <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= `APM_RST_RDATA;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `APM_ADDR_INACT_THRESH:  rdata <= cfg.inact_thresh;
        `APM_ADDR_INACT_TIME:    rdata <= cfg.inact_time;
        `APM_ADDR_RATE_SELECT:   rdata <= cfg.rate_select;
        `APM_ADDR_POWER_CONTROL: rdata <= cfg.power_control;
        default:                 rdata <= `APM_RST_RDATA;
      endcase
    end
  end

  AST_WRITE_HOLDS: assert property (@(posedge clock) disable iff (!nrst)
    bus.wr && bus.addr == `APM_ADDR_POWER_CONTROL |=>
      cfg.power_control == $past(bus.wdata))
    else $error("power control write not stored");

  AST_READ_BACK: assert property (@(posedge clock) disable iff (!nrst)
    bus.rd && !bus.wr && bus.addr == `APM_ADDR_RATE_SELECT |=>
      rdata == cfg.rate_select)
    else $error("rate select read data wrong");

endmodule : apm_regfile

// ===== dv/accel_power_mode_control_test.sv
`timescale 1ns/1ps

module accel_power_mode_control_test;
  import apm_pkg::*;

  // Shortened counts keep the whole run near 18k cycles
  localparam int BASE = 4;
  localparam int SEC  = 20;

  logic        clock;
  logic        nrst;
  apm_regbus_t reg_bus;
  apm_sample_t sample_in;
  logic [7:0]  reg_rdata;
  apm_mode_t   mode;
  logic        sensing_en;
  logic        low_power_active;
  logic        sample_tick;
  logic        convert_tick;
  int          errors;
  int          n_tests;
  int          cycles;
  int          lim_level;
  int          n;
  int          k;
  int          c;
  logic        kick;
  logic [7:0]  rd;
  logic [7:0]  shadow [4];
  logic [5:0]  addrs  [4];

  apm_top #(
    .BASE_CYCLES  (BASE),
    .SECOND_CYCLES(SEC)
  ) i_dut (
    .clock           (clock),
    .nrst            (nrst),
    .reg_bus         (reg_bus),
    .sample_in       (sample_in),
    .reg_rdata       (reg_rdata),
    .mode            (mode),
    .sensing_en      (sensing_en),
    .low_power_active(low_power_active),
    .sample_tick     (sample_tick),
    .convert_tick    (convert_tick)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic [31:0] period(input int code);
    int e;
    e = (code < 6) ? 6 : code;
    return 32'(BASE) << (15 - e);
  endfunction : period

  task summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  // Every cycle after reset passes here, so sample drive and timeout stay in step
  task step;
    @(posedge clock);
    #1;
    sample_in.valid = 1'b1;
    sample_in.x     = kick ? 8'hff : 8'($urandom_range(lim_level));
    sample_in.y     = 8'($urandom_range(lim_level));
    sample_in.z     = 8'($urandom_range(lim_level));
    cycles++;
    if (cycles > 40000) begin
      errors++;
      summarize();
    end
  endtask : step

  // The strobe rests low for one edge, so a following call never raises
  // it in the same time step that lowered it
  task wr(input logic [5:0] a, input logic [7:0] d);
    reg_bus.wr    = 1'b1;
    reg_bus.addr  = a;
    reg_bus.wdata = d;
    step();
    reg_bus.wr = 1'b0;
    for (int i = 0; i < 4; i++) if (addrs[i] == a) shadow[i] = d;
    step();
  endtask : wr

  task rd_reg(input logic [5:0] a);
    reg_bus.rd   = 1'b1;
    reg_bus.addr = a;
    step();
    reg_bus.rd = 1'b0;
    rd         = reg_rdata;
    step();
  endtask : rd_reg

  task read_all;
    for (int i = 0; i < 4; i++) begin
      rd_reg(addrs[i]);
      check(32'(rd), 32'(shadow[i]));
    end
  endtask : read_all

  // Counts cycles up to the next output data strobe
  task wait_tick(output int cnt);
    cnt = 0;
    do begin
      step();
      cnt++;
    end while (sample_tick !== 1'b1 && cnt < 5000);
    if (cnt >= 5000) check(32'(sample_tick), 32'h1);
  endtask : wait_tick

  // Steps until the mode reads sleep, bounded
  task wait_sleep(output int cnt);
    cnt = 0;
    do begin
      step();
      cnt++;
    end while (mode !== APM_SLEEP && cnt < 200);
  endtask : wait_sleep

  task kick_once;
    kick = 1'b1;
    step();
    kick = 1'b0;
  endtask : kick_once

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst      = 1'b0;
    reg_bus   = '0;
    sample_in = '0;
    kick      = 1'b0;
    errors    = 0;
    n_tests   = 0;
    cycles    = 0;
    lim_level = 0;
    addrs     = '{6'h25, 6'h26, 6'h2c, 6'h2d};
    shadow    = '{8'h00, 8'h00, 8'h0a, 8'h00};
    k         = $urandom(5);
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    check(32'(mode), 32'(APM_STANDBY));
    check(32'(sensing_en), 32'h0);
    read_all();
    $display("reset test done");

    for (int i = 0; i < 3; i++) wr(addrs[i], 8'($urandom));
    wr(6'h20, 8'h5a);
    rd_reg(6'h20);
    check(32'(rd), 32'h0);
    read_all();
    k = 0;
    repeat (100) begin
      step();
      if (sample_tick === 1'b1) k++;
    end
    check(32'(k), 32'h0);
    check(32'(mode), 32'(APM_STANDBY));
    $display("standby config test done");

    wr(6'h2c, 8'h0f);
    wr(6'h2d, 8'h08);
    step();
    step();
    check(32'(mode), 32'(APM_MEASURE));
    check(32'(sensing_en), 32'h1);
    // Code 5 is below the table and is expected to clamp
    for (c = 15; c >= 5; c--) begin
      wr(6'h2c, 8'(c));
      wait_tick(n);
      wait_tick(n);
      check(32'(n), period(c));
    end
    $display("rate code test done");

    wr(6'h2c, 8'h1c);
    wait_tick(n);
    k = 0;
    repeat (4) begin
      wait_tick(n);
      if (convert_tick === 1'b1) k++;
    end
    check(32'(k), 32'h2);
    check(32'(low_power_active), 32'h1);
    check(32'(n), period(12));
    wr(6'h2c, 8'h0c);
    wait_tick(n);
    k = 0;
    repeat (4) begin
      wait_tick(n);
      if (convert_tick === 1'b1) k++;
    end
    check(32'(k), 32'h4);
    check(32'(low_power_active), 32'h0);
    $display("low power test done");

    wr(6'h2d, 8'h00);
    step();
    step();
    check(32'(mode), 32'(APM_STANDBY));
    check(32'(sensing_en), 32'h0);
    repeat (3) step();
    k = 0;
    repeat (300) begin
      step();
      if (sample_tick === 1'b1) k++;
    end
    check(32'(k), 32'h0);
    read_all();
    $display("standby return test done");

    // Samples equal to the threshold must not count as activity
    lim_level = 8'h40;
    wr(6'h25, 8'h40);
    wr(6'h26, 8'h02);
    wr(6'h2c, 8'h0a);
    wr(6'h2d, 8'h18);
    repeat (120) step();
    check(32'(mode), 32'(APM_MEASURE));
    kick_once();
    wr(6'h2d, 8'h38);
    repeat (30) step();
    check(32'(mode), 32'(APM_MEASURE));
    kick_once();
    wait_sleep(n);
    check(32'(n >= 2 * SEC - 2 && n <= 2 * SEC + 6), 32'h1);
    check(32'(mode), 32'(APM_SLEEP));
    wait_tick(n);
    wait_tick(n);
    check(32'(n), period(6));
    check(32'(mode), 32'(APM_SLEEP));
    kick_once();
    repeat (2) step();
    check(32'(mode), 32'(APM_MEASURE));
    read_all();
    // Dropping the auto-sleep bit wakes the part, then sleep to standby
    wait_sleep(n);
    check(32'(mode), 32'(APM_SLEEP));
    wr(6'h2d, 8'h28);
    check(32'(mode), 32'(APM_MEASURE));
    repeat (60) step();
    check(32'(mode), 32'(APM_MEASURE));
    wr(6'h2d, 8'h38);
    wait_sleep(n);
    check(32'(mode), 32'(APM_SLEEP));
    wr(6'h2d, 8'h00);
    check(32'(mode), 32'(APM_STANDBY));
    check(32'(sensing_en), 32'h0);
    $display("autosleep test done");
    summarize();
  end

endmodule : accel_power_mode_control_test
